/* verilog/pca_initiator.sv */
// apb-facing pci configuration access initiator: direct and indirect modes
// assumes an apb master on pclk and pci target answers synchronous to pclk
`timescale 1ns/100ps
module pca_initiator
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic [31:0] pci_address_data_lines_in,
   output logic [31:0] pci_address_data_lines_out,
   output logic pci_address_data_lines_oe,
   output logic [3:0] pci_cbe,
   output logic pci_addr_phase,
   output logic pci_data_phase,
   input wire logic pci_target_ack,
   input wire logic pci_target_retry
);
   import pca_pkg::*;

   logic [31:0] chip_configuration;
   logic [31:0] direct_cfg_address;
   logic [31:0] direct_cfg_data;
   logic [31:0] indirect_target_address;
   logic [31:0] indirect_transfer_data;
   logic [7:0] indirect_command_byte_enable;
   logic [31:0] initiator_status;
   logic [31:0] interrupt_mask;
   logic direct_launched;
   logic indirect_owner;
   logic [9:0] wait_count;
   logic eng_busy;
   logic eng_done;
   logic [31:0] eng_rdata;
   pca_pci_out_type eng_pci_out;
   pca_req_type eng_req;
   logic [31:0] read_value;
   logic read_hit;
   logic [31:0] next_status;

   // bus phases: access is any access cycle not yet answered, commit the ending edge
   wire logic access = psel && penable && !pready;
   wire logic commit = psel && penable && pready;
   wire logic wr_commit = commit && pwrite;
   wire logic sel_status = (paddr == ADDR_INITIATOR_STATUS);
   wire logic sel_mask = (paddr == ADDR_INTERRUPT_MASK);
   wire logic sel_direct_addr = (paddr == ADDR_DIRECT_CFG_ADDRESS);
   wire logic sel_direct_data = (paddr == ADDR_DIRECT_CFG_DATA);
   wire logic sel_ind_addr = (paddr == ADDR_INDIRECT_TARGET_ADDRESS);
   wire logic sel_ind_data = (paddr == ADDR_INDIRECT_TRANSFER_DATA);
   wire logic sel_ind_cbe = (paddr == ADDR_INDIRECT_COMMAND_BYTE_ENABLE);
   wire logic sel_chip_configuration = (paddr == ADDR_CHIP_CONFIGURATION);

   wire logic timeout_enabled = chip_configuration[TIMEOUT_BUSERR_ENABLE_BIT];

   // irq follows a mask written at the same edge, so no stale interrupt cycle follows the write
   wire logic [31:0] next_mask = (wr_commit && sel_mask) ? (pwdata & STATUS_BITS) : interrupt_mask;

   // a direct access waits for an idle engine before it launches
   wire logic direct_start = access && sel_direct_data && !direct_launched && !eng_busy;
   // the indirect launch rides on the write that commits, which itself is answered at once
   wire logic indirect_start = wr_commit && sel_ind_cbe && !eng_busy && !direct_launched;
   wire logic eng_start = direct_start || indirect_start;

   wire logic direct_done = direct_launched && eng_done && !indirect_owner;
   // retries never clear the counter, so a retry loop still reaches the limit
   wire logic timeout_hit = direct_launched && timeout_enabled && !eng_done
      && (wait_count == TIMEOUT_LAST);
   wire logic indirect_done = indirect_owner && eng_done;
   wire logic indirect_read_done = indirect_done
      && (indirect_command_byte_enable[CMD_MSB:CMD_LSB] != CMD_CFG_WRITE);

   wire logic [3:0] ind_cmd = indirect_command_byte_enable[CMD_MSB:CMD_LSB];
   wire logic [3:0] ind_be = indirect_command_byte_enable[BE_MSB:BE_LSB];
   wire logic [3:0] direct_cmd = pwrite ? CMD_CFG_WRITE : CMD_CFG_READ;

   always_comb
   begin
      eng_req = '0;
      if (direct_start)
      begin
         eng_req.addr = direct_cfg_address;
         eng_req.cmd = direct_cmd;
         eng_req.be = BE_ALL_LANES;
         eng_req.wdata = pwdata;
      end
      else
      begin
         eng_req.addr = indirect_target_address;
         eng_req.cmd = pwdata[CMD_MSB:CMD_LSB];
         eng_req.be = pwdata[BE_MSB:BE_LSB];
         eng_req.wdata = indirect_transfer_data;
      end
   end

   // one engine serves both modes; each launch checks that the engine is idle, the indirect one also that no direct access is pending
   pca_cycle_engine u_engine
   (
      .pclk(pclk),
      .presetn(presetn),
      .start(eng_start),
      .abort(timeout_hit),
      .req(eng_req),
      .pci_ad_in(pci_address_data_lines_in),
      .target_ack(pci_target_ack),
      .target_retry(pci_target_retry),
      .busy(eng_busy),
      .done(eng_done),
      .rdata(eng_rdata),
      .pci_out(eng_pci_out)
   );

   assign pci_address_data_lines_out = eng_pci_out.ad_out;
   assign pci_address_data_lines_oe = eng_pci_out.ad_oe;
   assign pci_cbe = eng_pci_out.cbe;
   assign pci_addr_phase = eng_pci_out.addr_phase;
   assign pci_data_phase = eng_pci_out.data_phase;

   // reads of the command register show only the low byte; the rest reads as zero
   always_comb
   begin
      read_value = 32'h00000000;
      read_hit = 1'b1;
      unique case (1'b1)
         sel_status: read_value = initiator_status;
         sel_mask: read_value = interrupt_mask;
         sel_direct_addr: read_value = direct_cfg_address;
         sel_direct_data: read_value = direct_cfg_data;
         sel_ind_addr: read_value = indirect_target_address;
         sel_ind_data: read_value = indirect_transfer_data;
         sel_ind_cbe: read_value = {24'h000000, indirect_command_byte_enable};
         sel_chip_configuration: read_value = chip_configuration;
         default: read_hit = 1'b0;
      endcase
   end

   // set wins over a write-one clear landing in the same cycle
   always_comb
   begin
      next_status = initiator_status;
      if (wr_commit && sel_status)
      begin
         next_status = initiator_status & ~(pwdata & STATUS_BITS);
      end
      if (indirect_done)
      begin
         next_status[INDIRECT_COMMAND_COMPLETE_BIT] = 1'b1;
      end
      // bit 11 lets software tell a direct-access timeout from other bus errors
      if (timeout_hit)
      begin
         next_status[DIRECT_TIMEOUT_BIT] = 1'b1;
      end
   end

   // apb answer: pready rises one edge after the first access cycle for plain registers,
   // and only when the pci cycle ends (or times out) for the direct data register
   // pslverr on an unmapped address keeps a stray pointer from reading zero silently
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else if (pready)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (access && sel_direct_data)
      begin
         if (direct_done)
         begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h00000000 : eng_rdata;
         end
         else if (timeout_hit)
         begin
            pready <= 1'b1;
            pslverr <= 1'b1;
            prdata <= 32'h00000000;
         end
      end
      else if (access)
      begin
         pready <= 1'b1;
         pslverr <= !read_hit;
         prdata <= pwrite ? 32'h00000000 : read_value;
      end
   end

   // the owner flag blocks writes to the indirect address and data while the pci cycle runs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         direct_launched <= 1'b0;
         indirect_owner <= 1'b0;
      end
      else
      begin
         if (direct_start)
         begin
            direct_launched <= 1'b1;
         end
         else if (direct_done || timeout_hit)
         begin
            direct_launched <= 1'b0;
         end
         if (indirect_start)
         begin
            indirect_owner <= 1'b1;
         end
         else if (eng_done)
         begin
            indirect_owner <= 1'b0;
         end
      end
   end

   // clearing the enable mid-wait restarts the count; the access then waits without limit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wait_count <= 10'h000;
      end
      else if (!direct_launched || !timeout_enabled || timeout_hit)
      begin
         wait_count <= 10'h000;
      end
      else
      begin
         wait_count <= wait_count + 10'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         chip_configuration <= CHIP_CONFIGURATION_RESET;
         direct_cfg_address <= REG_RESET;
         indirect_target_address <= REG_RESET;
         interrupt_mask <= REG_RESET;
         indirect_command_byte_enable <= 8'h00;
      end
      else if (wr_commit)
      begin
         if (sel_chip_configuration)
         begin
            chip_configuration <= pwdata;
         end
         if (sel_direct_addr)
         begin
            direct_cfg_address <= pwdata;
         end
         if (sel_ind_addr && !indirect_owner)
         begin
            indirect_target_address <= pwdata;
         end
         if (sel_mask)
         begin
            interrupt_mask <= pwdata & STATUS_BITS;
         end
         if (indirect_start)
         begin
            indirect_command_byte_enable <= pwdata[7:0] & CBE_FIELDS;
         end
      end
   end

   // data registers have a hardware writer too; the pci result takes precedence
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         direct_cfg_data <= REG_RESET;
         indirect_transfer_data <= REG_RESET;
      end
      else
      begin
         if (direct_done && !pwrite)
         begin
            direct_cfg_data <= eng_rdata;
         end
         else if (wr_commit && sel_direct_data)
         begin
            direct_cfg_data <= pwdata;
         end
         if (indirect_read_done)
         begin
            indirect_transfer_data <= eng_rdata;
         end
         else if (wr_commit && sel_ind_data && !indirect_owner)
         begin
            indirect_transfer_data <= pwdata;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         initiator_status <= REG_RESET;
         irq <= 1'b0;
      end
      else
      begin
         initiator_status <= next_status;
         irq <= |(next_status & next_mask);
      end
   end
endmodule

/* verilog/pca_pkg.sv */
// constants and carrier types for the pci configuration access initiator
// assumes a 32-bit apb slave port on the internal bus clock
package pca_pkg;
   localparam logic [31:0] ADDR_INITIATOR_STATUS = 32'hfffed044;
   localparam logic [31:0] ADDR_INTERRUPT_MASK = 32'hfffed048;
   localparam logic [31:0] ADDR_DIRECT_CFG_ADDRESS = 32'hfffed138;
   localparam logic [31:0] ADDR_DIRECT_CFG_DATA = 32'hfffed13c;
   localparam logic [31:0] ADDR_INDIRECT_TARGET_ADDRESS = 32'hfffed150;
   localparam logic [31:0] ADDR_INDIRECT_TRANSFER_DATA = 32'hfffed154;
   localparam logic [31:0] ADDR_INDIRECT_COMMAND_BYTE_ENABLE = 32'hfffed158;
   localparam logic [31:0] ADDR_CHIP_CONFIGURATION = 32'hfffee000;
   localparam int TIMEOUT_BUSERR_ENABLE_BIT = 14;
   localparam int INDIRECT_COMMAND_COMPLETE_BIT = 12;
   localparam int DIRECT_TIMEOUT_BIT = 11;
   localparam logic [31:0] STATUS_BITS = 32'h00001800;
   localparam int CMD_MSB = 7;
   localparam int CMD_LSB = 4;
   localparam int BE_MSB = 3;
   localparam int BE_LSB = 0;
   localparam logic [7:0] CBE_FIELDS = 8'hff;
   localparam logic [3:0] CMD_CFG_READ = 4'ha;
   localparam logic [3:0] CMD_CFG_WRITE = 4'hb;
   localparam logic [3:0] BE_ALL_LANES = 4'h0;
   localparam logic [31:0] CHIP_CONFIGURATION_RESET = 32'h00000000;
   localparam logic [31:0] REG_RESET = 32'h00000000;
   localparam int TIMEOUT_CLOCKS = 512;
   localparam logic [9:0] TIMEOUT_LAST = 10'(TIMEOUT_CLOCKS - 1);
   typedef struct packed
   {
      logic [31:0] addr;
      logic [3:0] cmd;
      logic [3:0] be;
      logic [31:0] wdata;
   } pca_req_type;
   typedef struct packed
   {
      logic [31:0] ad_out;
      logic ad_oe;
      logic [3:0] cbe;
      logic addr_phase;
      logic data_phase;
   } pca_pci_out_type;
   typedef enum logic [1:0]
   {
      ENG_IDLE = 2'b00,
      ENG_ADDR = 2'b01,
      ENG_DATA = 2'b10
   } pca_eng_state_type;
endpackage

/* verilog/pca_cycle_engine.sv */
// pci configuration cycle engine: address phase, data phase, retry reissue
// assumes target answers (ack, retry, read data) are logic on the same clock
`timescale 1ns/100ps
module pca_cycle_engine
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic abort,
   input wire pca_pkg::pca_req_type req,
   input wire logic [31:0] pci_ad_in,
   input wire logic target_ack,
   input wire logic target_retry,
   output logic busy,
   output logic done,
   output logic [31:0] rdata,
   output pca_pkg::pca_pci_out_type pci_out
);
   import pca_pkg::*;
   pca_eng_state_type state;
   pca_eng_state_type next_state;
   pca_req_type held;
   pca_pci_out_type next_pci_out;
   wire logic is_write = held.cmd[0];
   always_comb
   begin
      next_state = state;
      next_pci_out = '0;
      unique case (state)
         ENG_IDLE:
         begin
            if (start)
            begin
               next_state = ENG_ADDR;
            end
         end
         ENG_ADDR:
         begin
            next_state = ENG_DATA;
         end
         ENG_DATA:
         begin
            // a retry reissues the whole cycle; the caller's timer keeps running
            if (target_ack)
            begin
               next_state = ENG_IDLE;
            end
            else if (target_retry)
            begin
               next_state = ENG_ADDR;
            end
         end
         default:
         begin
            next_state = ENG_IDLE;
         end
      endcase
      if (abort)
      begin
         next_state = ENG_IDLE;
      end
      if (next_state == ENG_ADDR)
      begin
         next_pci_out.ad_out = (state == ENG_IDLE) ? req.addr : held.addr;
         next_pci_out.ad_oe = 1'b1;
         next_pci_out.cbe = (state == ENG_IDLE) ? req.cmd : held.cmd;
         next_pci_out.addr_phase = 1'b1;
      end
      else if (next_state == ENG_DATA)
      begin
         next_pci_out.ad_out = is_write ? held.wdata : 32'h00000000;
         next_pci_out.ad_oe = is_write;
         next_pci_out.cbe = held.be;
         next_pci_out.data_phase = 1'b1;
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= ENG_IDLE;
         held <= '0;
         pci_out <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         rdata <= 32'h00000000;
      end
      else
      begin
         state <= next_state;
         pci_out <= next_pci_out;
         busy <= (next_state != ENG_IDLE);
         done <= (state == ENG_DATA) && target_ack && !abort;
         if (state == ENG_IDLE && start)
         begin
            held <= req;
         end
         if (state == ENG_DATA && target_ack && !is_write)
         begin
            rdata <= pci_ad_in;
         end
      end
   end
endmodule

/* verif/pca_target_model.sv */
// pci target model answering configuration cycles of the initiator
// assumes answers are combinational and sampled by the initiator on pclk
`timescale 1ns/100ps
module pca_target_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic data_phase,
   input wire logic [1:0] mode,
   input wire logic [31:0] value,
   output logic ack,
   output logic retry,
   output logic [31:0] ad
);
   // mode 0 acks at once, 1 after six data cycles, 2 retries forever, 3 stays silent
   logic [2:0] waited;
   logic [31:0] last;
   assign ack = data_phase && (mode == 2'd0 || (mode == 2'd1 && waited == 3'd6));
   assign retry = data_phase && mode == 2'd2;
   // released lines toggle so a stale value never passes for read data
   assign ad = ack ? value : ~last;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         waited <= '0;
         last <= '0;
      end
      else
      begin
         waited <= (data_phase && !ack) ? waited + 3'd1 : 3'd0;
         last <= ad;
      end
endmodule

/* verif/pca_initiator_checker.sv */
// port assertions for the configuration access initiator
// assumes binding into pca_initiator, one clock domain
`timescale 1ns/100ps
module pca_initiator_checker
import pca_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] pci_address_data_lines_out,
   input wire logic pci_address_data_lines_oe,
   input wire logic [3:0] pci_cbe,
   input wire logic pci_addr_phase,
   input wire logic pci_data_phase,
   input wire logic pci_target_ack
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // shadow copies rebuilt from bus traffic, since the checker cannot see registers
   logic [10:0] cnt;
   logic timeout_buserr_enable;
   logic [31:0] dir_addr;
   logic [31:0] ind_addr;
   logic [3:0] ind_cmd;
   wire wr = pready && pwrite && !pslverr;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         cnt <= '0;
      else if (pready)
         cnt <= '0;
      else if (psel && penable && paddr == ADDR_DIRECT_CFG_DATA && cnt != 11'h7ff)
         cnt <= cnt + 11'd1;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         timeout_buserr_enable <= 1'b0;
         dir_addr <= '0;
         ind_addr <= '0;
         ind_cmd <= '0;
      end
      else if (wr)
      begin
         timeout_buserr_enable <= (paddr == ADDR_CHIP_CONFIGURATION) ? pwdata[TIMEOUT_BUSERR_ENABLE_BIT] : timeout_buserr_enable;
         dir_addr <= (paddr == ADDR_DIRECT_CFG_ADDRESS) ? pwdata : dir_addr;
         ind_addr <= (paddr == ADDR_INDIRECT_TARGET_ADDRESS) ? pwdata : ind_addr;
         ind_cmd <= (paddr == ADDR_INDIRECT_COMMAND_BYTE_ENABLE) ? pwdata[CMD_MSB:CMD_LSB] : ind_cmd;
      end
   sequence s_first;
      psel && penable && !$past(penable);
   endsequence
   sequence s_direct;
      s_first ##0 paddr == ADDR_DIRECT_CFG_DATA;
   endsequence
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   a_error_with_ready: assert property (pslverr |-> pready && psel && penable) else $error("stray pslverr");
   a_plain_quick: assert property (s_first ##0 paddr != ADDR_DIRECT_CFG_DATA |=> pready)
      else $error("plain access not answered in one cycle");
   a_direct_stall: assert property (s_direct |=> !pready [*3])
      else $error("direct access answered before the pci cycle");
   a_direct_launch: assert property (s_direct ##0 !pwrite |=> pci_addr_phase && pci_cbe == CMD_CFG_READ
      && pci_address_data_lines_out == dir_addr) else $error("direct read not launched");
   a_read_release: assert property (pci_addr_phase && pci_cbe == CMD_CFG_READ
      |=> pci_data_phase && !pci_address_data_lines_oe) else $error("read data phase wrong");
   a_ack_ends_cycle: assert property (pci_data_phase && pci_target_ack && psel
      && paddr == ADDR_DIRECT_CFG_DATA |=> !pready ##1 pready) else $error("direct cycle end wrong");
   a_indirect_launch: assert property (wr && paddr == ADDR_INDIRECT_COMMAND_BYTE_ENABLE
      |=> pci_addr_phase && pci_address_data_lines_oe && pci_address_data_lines_out == ind_addr
      && pci_cbe == ind_cmd) else $error("indirect address phase wrong");
   // cnt is 1 after the launch edge, so the answer driven 512 edges later is sampled at 513
   a_timeout_bound: assert property (timeout_buserr_enable && cnt == 11'd513 |-> pready)
      else $error("timeout not taken after 512 clocks");
   a_error_needs_enable: assert property (pslverr && paddr == ADDR_DIRECT_CFG_DATA
      |-> timeout_buserr_enable && cnt == 11'd513) else $error("bus error without enabled timeout");
endmodule
bind pca_initiator pca_initiator_checker checker_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pready, .pslverr, .pci_address_data_lines_out, .pci_address_data_lines_oe, .pci_cbe,
   .pci_addr_phase, .pci_data_phase, .pci_target_ack);

/* verif/testbench.sv */
// self-checking bench for the configuration access initiator
// assumes the target model answers the pci side
`timescale 1ns/100ps
module testbench;
   import pca_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, oe, aph, dph, ack, retry, err;
   logic [31:0] paddr, pwdata, prdata, ad_in, ad_out, value, rd, wd, ad_seen;
   logic [3:0] cbe, be_seen, cmd, be;
   logic [1:0] mode;
   int mismatches, compares, n, k;
   pca_initiator DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .irq, .pci_address_data_lines_in(ad_in), .pci_address_data_lines_out(ad_out),
      .pci_address_data_lines_oe(oe), .pci_cbe(cbe), .pci_addr_phase(aph), .pci_data_phase(dph),
      .pci_target_ack(ack), .pci_target_retry(retry));
   pca_target_model target (.pclk, .presetn, .data_phase(dph), .mode, .value, .ack, .retry, .ad(ad_in));
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk)
      if (dph === 1'b1)
      begin
         be_seen <= cbe;
         ad_seen <= ad_out;
      end
   function automatic logic [31:0] exp_data(input logic [3:0] c, input logic [31:0] w, input logic [31:0] t);
      return (c == CMD_CFG_WRITE) ? w : t;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 2000);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 2000)
      begin
         mismatches++;
         stop_test();
      end
   endtask
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      mode = 2'd0;
      value = '0;
      mismatches = 0;
      compares = 0;
      void'($urandom(68));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, ADDR_CHIP_CONFIGURATION, 0);
      chk(rd, CHIP_CONFIGURATION_RESET);
      apb(0, 32'hfffed000, 0);
      chk({rd[30:0], err}, 32'h1);
      for (int i = 0; i < 6; i++)
      begin
         mode <= 2'($urandom_range(1));
         value <= $urandom;
         apb(1, ADDR_DIRECT_CFG_ADDRESS, $urandom);
         wd = $urandom;
         apb(i[0], ADDR_DIRECT_CFG_DATA, wd);
         chk({31'h0, err}, 32'h0);
         // a write is checked on the data lines, a read in the returned word
         chk(i[0] ? ad_seen : rd, i[0] ? wd : value);
      end
      apb(1, ADDR_CHIP_CONFIGURATION, 32'h1 << TIMEOUT_BUSERR_ENABLE_BIT);
      for (int i = 2; i < 4; i++)
      begin
         mode <= 2'(i);
         apb(i[0], ADDR_DIRECT_CFG_DATA, $urandom);
         chk({31'h0, err}, 32'h1);
         // n is 1 at the launch edge; pready driven 512 edges later is sampled one edge after
         chk(32'(n), 32'd514);
         apb(0, ADDR_INITIATOR_STATUS, 0);
         chk(rd, 32'h1 << DIRECT_TIMEOUT_BIT);
         apb(1, ADDR_INITIATOR_STATUS, rd);
      end
      apb(1, ADDR_INTERRUPT_MASK, STATUS_BITS);
      for (int i = 0; i < 6; i++)
      begin
         cmd = i[0] ? CMD_CFG_WRITE : CMD_CFG_READ;
         be = 4'($urandom);
         wd = $urandom;
         mode <= 2'($urandom_range(1));
         value <= $urandom;
         // the last two runs leave the interrupt masked
         if (i == 4)
            apb(1, ADDR_INTERRUPT_MASK, 0);
         apb(1, ADDR_INDIRECT_TARGET_ADDRESS, $urandom);
         apb(1, ADDR_INDIRECT_TRANSFER_DATA, wd);
         apb(1, ADDR_INDIRECT_COMMAND_BYTE_ENABLE, {24'h0, cmd, be});
         // a plain answer is sampled at the second edge of the access phase
         chk(32'(n), 32'd2);
         k = 0;
         do
         begin
            apb(0, ADDR_INITIATOR_STATUS, 0);
            k++;
         end
         while (rd[INDIRECT_COMMAND_COMPLETE_BIT] !== 1'b1 && k < 50);
         chk(rd, 32'h1 << INDIRECT_COMMAND_COMPLETE_BIT);
         chk({31'h0, irq}, {31'h0, i < 4});
         chk({28'h0, be_seen}, {28'h0, be});
         if (cmd == CMD_CFG_WRITE)
            chk(ad_seen, wd);
         apb(0, ADDR_INDIRECT_TRANSFER_DATA, 0);
         chk(rd, exp_data(cmd, wd, value));
         apb(1, ADDR_INITIATOR_STATUS, 32'h1 << INDIRECT_COMMAND_COMPLETE_BIT);
         apb(0, ADDR_INITIATOR_STATUS, 0);
         chk({rd[30:0], irq}, 32'h0);
      end
      apb(1, ADDR_CHIP_CONFIGURATION, 0);
      mode <= 2'd3;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= 1'b0;
      paddr <= ADDR_DIRECT_CFG_DATA;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      repeat (1200)
      begin
         @(posedge pclk);
         k += (pready !== 1'b0);
      end
      chk(32'(k), 32'd0);
      // a supervisor reset is the only way out of the stalled access
      presetn <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, ADDR_CHIP_CONFIGURATION, 0);
      chk(rd, CHIP_CONFIGURATION_RESET);
      stop_test();
   end
endmodule
